/* File: hdl/upl_pkg.sv */
// Shared constants for the user program logic instruction engine.
package upl_pkg;
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int IW = 16;
    localparam int RW = 16;

    // Instruction fields: first byte in bits 15..8, operand in bits 7..0.
    localparam int OPC_HI  = 15;
    localparam int OPC_LO  = 12;
    localparam int OPND_BIT = 11;
    localparam int DIR_BIT  = 11;
    localparam int SUBJ_HI = 10;
    localparam int SUBJ_LO = 8;
    localparam int COND_HI = 9;
    localparam int COND_LO = 8;

    localparam logic [3:0] OP_AND     = 4'h1;
    localparam logic [3:0] OP_TESTAND = 4'h2;
    localparam logic [3:0] OP_COMPARE = 4'h3;
    localparam logic [3:0] OP_BRANCH  = 4'h4;
    localparam logic [3:0] OP_MOVE    = 4'h5;

    localparam logic [AW-1:0] LEN_SHORT = 8'h01;
    localparam logic [AW-1:0] LEN_LONG  = 8'h02;

    localparam logic [1:0] COND_ALWAYS  = 2'h0;
    localparam logic [1:0] COND_NONZERO = 2'h1;
    localparam logic [1:0] COND_ZERO    = 2'h2;

    typedef enum logic [2:0] {
        SUBJ_RX0   = 3'h0,
        SUBJ_RX1   = 3'h1,
        SUBJ_CTRL  = 3'h2,
        SUBJ_NEXUS = 3'h3,
        SUBJ_INT   = 3'h4,
        SUBJ_STEP  = 3'h5,
        SUBJ_SCSI  = 3'h6,
        SUBJ_ACC   = 3'h7
    } upl_subj_e;

    // Register map of the software port.
    localparam logic [1:0] REG_CONTROL = 2'h0;
    localparam logic [1:0] REG_STATUS  = 2'h1;
    localparam logic [1:0] REG_ACC     = 2'h2;
    localparam logic [1:0] REG_COND    = 2'h3;
    localparam int CTRL_RUN_BIT  = 8;
    localparam int STAT_RUN_BIT  = 0;
    localparam int STAT_ZERO_BIT = 1;
    localparam int STAT_ILL_BIT  = 2;

    localparam logic [DW-1:0] ACC_RESET  = 8'h00;
    localparam logic [DW-1:0] COND_RESET = 8'h00;
    localparam logic [AW-1:0] PC_RESET   = 8'h00;

    // Two-byte instructions are the only ones this engine executes.
    function automatic logic isKnownOp(input logic [3:0] opc);
        return (opc == OP_AND) || (opc == OP_TESTAND) || (opc == OP_COMPARE) ||
               (opc == OP_BRANCH) || (opc == OP_MOVE);
    endfunction : isKnownOp
endpackage : upl_pkg

/* File: hdl/upl_source_sel.sv */
// Subject code source selector with queue advance strobes.
`timescale 1ns/1ps
module upl_source_sel (
    // Status sources
    input  wire logic [upl_pkg::DW-1:0] rxByte0,
    input  wire logic [upl_pkg::DW-1:0] rxByte1,
    input  wire logic [upl_pkg::DW-1:0] ctrlStatus,
    input  wire logic [upl_pkg::DW-1:0] nexusStatus,
    input  wire logic [upl_pkg::DW-1:0] intStatus,
    input  wire logic [upl_pkg::DW-1:0] cmdStep,
    input  wire logic [upl_pkg::DW-1:0] scsiCtrl,
    input  wire logic [upl_pkg::DW-1:0] acc,
    // Selection
    input  wire logic [2:0]             subjectSel,
    input  wire logic                   take,
    // Result
    output logic      [upl_pkg::DW-1:0] value,
    output logic                        popInt,
    output logic                        popStep
);
    wire logic [upl_pkg::DW-1:0] srcs [8];

    assign srcs[upl_pkg::SUBJ_RX0]   = rxByte0;
    assign srcs[upl_pkg::SUBJ_RX1]   = rxByte1;
    assign srcs[upl_pkg::SUBJ_CTRL]  = ctrlStatus;
    assign srcs[upl_pkg::SUBJ_NEXUS] = nexusStatus;
    assign srcs[upl_pkg::SUBJ_INT]   = intStatus;
    assign srcs[upl_pkg::SUBJ_STEP]  = cmdStep;
    assign srcs[upl_pkg::SUBJ_SCSI]  = scsiCtrl;
    assign srcs[upl_pkg::SUBJ_ACC]   = acc;

    assign value   = srcs[subjectSel];
    // Each access moves the queue on so a pending cause shows next time.
    assign popInt  = take && (subjectSel == upl_pkg::SUBJ_INT);
    assign popStep = take && (subjectSel == upl_pkg::SUBJ_STEP);
endmodule : upl_source_sel

/* File: hdl/upl_logic_unit.sv */
// Bitwise product and equality difference of two bytes.
`timescale 1ns/1ps
module upl_logic_unit (
    // Inputs
    input  wire logic [upl_pkg::DW-1:0] subject,
    input  wire logic [upl_pkg::DW-1:0] operand,
    // Results
    output logic      [upl_pkg::DW-1:0] andOut,
    output logic      [upl_pkg::DW-1:0] cmpOut
);
    for (genvar i = 0; i < upl_pkg::DW; i++) begin : g_bit
        assign andOut[i] = subject[i] & operand[i];
    end
    // Zero exactly when equal, so zero/nonzero branches mean equal/unequal.
    assign cmpOut = subject ^ operand;
endmodule : upl_logic_unit

/* File: hdl/upl_core.sv */
// User program engine for logic, compare, branch and move instructions.
`timescale 1ns/1ps
module upl_core (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Software register port
    input  wire logic [1:0]             regAddr,
    input  wire logic [upl_pkg::RW-1:0] regWrData,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [upl_pkg::RW-1:0] regRdData,
    // User program memory, synchronous read
    output logic      [upl_pkg::AW-1:0] memAddr,
    input  wire logic [upl_pkg::DW-1:0] memRdData,
    output logic                        memWr,
    output logic      [upl_pkg::DW-1:0] memWrData,
    // Status sources
    input  wire logic [upl_pkg::DW-1:0] rxByte0,
    input  wire logic [upl_pkg::DW-1:0] rxByte1,
    input  wire logic [upl_pkg::DW-1:0] ctrlStatus,
    input  wire logic [upl_pkg::DW-1:0] nexusStatus,
    input  wire logic [upl_pkg::DW-1:0] intStatus,
    input  wire logic [upl_pkg::DW-1:0] cmdStep,
    input  wire logic [upl_pkg::DW-1:0] scsiCtrl,
    // Queue advance strobes
    output logic                        popInt,
    output logic                        popStep
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD  = 3'b001,
        ST_OPD  = 3'b011,
        ST_IND  = 3'b010,
        ST_AWT  = 3'b110,
        ST_EXEC = 3'b111
    } upl_state_e;

    upl_state_e                 state;
    upl_state_e                 next_state;
    logic [upl_pkg::AW-1:0]     pc;
    logic [upl_pkg::DW-1:0]     cmdByte;
    logic [upl_pkg::DW-1:0]     opnd;
    logic [upl_pkg::DW-1:0]     acc;
    logic [upl_pkg::DW-1:0]     condVal;
    logic                       running;
    logic                       illegal;

    // Decode of the held command byte.
    wire logic [upl_pkg::IW-1:0] instr = {cmdByte, opnd};
    wire logic [3:0] opc     = instr[upl_pkg::OPC_HI:upl_pkg::OPC_LO];
    wire logic       opBit   = instr[upl_pkg::OPND_BIT];
    wire logic [2:0] subjSel = instr[upl_pkg::SUBJ_HI:upl_pkg::SUBJ_LO];
    wire logic [1:0] condSel = instr[upl_pkg::COND_HI:upl_pkg::COND_LO];
    wire logic isAnd   = (opc == upl_pkg::OP_AND);
    wire logic isTest  = (opc == upl_pkg::OP_TESTAND);
    wire logic isCmp   = (opc == upl_pkg::OP_COMPARE);
    wire logic isBr    = (opc == upl_pkg::OP_BRANCH);
    wire logic isMove  = (opc == upl_pkg::OP_MOVE);
    wire logic isCalc  = isAnd || isTest || isCmp;
    wire logic isStore = isMove && instr[upl_pkg::DIR_BIT];
    wire logic isLoad  = isMove && !instr[upl_pkg::DIR_BIT];
    // Operand is an address for calculations with bit 11 set and for MOVE loads.
    wire logic needInd = (isCalc && opBit) || isLoad;

    // Opcode of the byte arriving from memory during ST_OPD.
    wire logic [3:0] newOpc = memRdData[upl_pkg::OPC_HI-upl_pkg::DW:upl_pkg::OPC_LO-upl_pkg::DW];
    wire logic       newOk  = upl_pkg::isKnownOp(newOpc);

    // Data operand: immediate byte or the byte fetched from the operand address.
    wire logic [upl_pkg::DW-1:0] calcOperand = (isCalc && opBit) ? memRdData : opnd;

    wire logic [upl_pkg::DW-1:0] subjVal;
    wire logic [upl_pkg::DW-1:0] andRes;
    wire logic [upl_pkg::DW-1:0] cmpRes;
    wire logic takeExec  = (state == ST_EXEC) && isCalc;
    wire logic takeStore = (state == ST_IND) && isStore;

    upl_source_sel u_src (
        .rxByte0     (rxByte0),
        .rxByte1     (rxByte1),
        .ctrlStatus  (ctrlStatus),
        .nexusStatus (nexusStatus),
        .intStatus   (intStatus),
        .cmdStep     (cmdStep),
        .scsiCtrl    (scsiCtrl),
        .acc         (acc),
        .subjectSel  (subjSel),
        .take        (takeExec || takeStore),
        .value       (subjVal),
        .popInt      (popInt),
        .popStep     (popStep)
    );

    upl_logic_unit u_alu (
        .subject (subjVal),
        .operand (calcOperand),
        .andOut  (andRes),
        .cmpOut  (cmpRes)
    );

    // Branch decision on the latest kept result.
    localparam logic [upl_pkg::DW-1:0] COND_ZERO_VAL = upl_pkg::COND_RESET;
    wire logic condZero = (condVal == COND_ZERO_VAL);
    wire logic brTaken = isBr && ((condSel == upl_pkg::COND_ALWAYS) ||
                                  ((condSel == upl_pkg::COND_NONZERO) && !condZero) ||
                                  ((condSel == upl_pkg::COND_ZERO) && condZero));
    // Every executed instruction here is two bytes long.
    wire logic [upl_pkg::AW-1:0] pcNext = pc + upl_pkg::LEN_LONG;
    wire logic [upl_pkg::AW-1:0] pcOpd  = pc + upl_pkg::LEN_SHORT;

    // Software writes.
    wire logic wrCtrl  = regWr && (regAddr == upl_pkg::REG_CONTROL);
    wire logic wrAcc   = regWr && (regAddr == upl_pkg::REG_ACC);
    wire logic runReq  = wrCtrl && regWrData[upl_pkg::CTRL_RUN_BIT];
    wire logic stopReq = wrCtrl && !regWrData[upl_pkg::CTRL_RUN_BIT];
    wire logic badOp   = (state == ST_OPD) && !newOk;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (runReq) next_state = ST_CMD;
            ST_CMD:  next_state = ST_OPD;
            ST_OPD:  next_state = newOk ? ST_IND : ST_IDLE;
            ST_IND:  next_state = (needInd || isStore) ? ST_AWT : ST_EXEC;
            ST_AWT:  next_state = ST_EXEC;
            ST_EXEC: next_state = ST_CMD;
            default: next_state = ST_IDLE;
        endcase
        if (stopReq) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Program counter.
    wire logic [upl_pkg::AW-1:0] next_pc =
        (state == ST_IDLE && runReq) ? regWrData[upl_pkg::AW-1:0] :
        (state == ST_EXEC)           ? (brTaken ? opnd : pcNext) : pc;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc <= upl_pkg::PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    // Command and operand bytes arrive one cycle after their address.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmdByte <= '0;
            opnd    <= '0;
        end else begin
            if (state == ST_OPD) begin
                cmdByte <= memRdData;
            end
            if (state == ST_IND) begin
                opnd <= memRdData;
            end
        end
    end

    // Memory address and store port.
    wire logic [upl_pkg::AW-1:0] next_memAddr =
        (state == ST_IDLE) ? regWrData[upl_pkg::AW-1:0] :
        (state == ST_CMD)  ? pcOpd :
        (state == ST_IND)  ? memRdData :
        (state == ST_EXEC) ? next_pc : memAddr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            memAddr   <= upl_pkg::PC_RESET;
            memWr     <= 1'b0;
            memWrData <= '0;
        end else begin
            memAddr   <= next_memAddr;
            memWr     <= takeStore && !stopReq;
            memWrData <= takeStore ? subjVal : memWrData;
        end
    end

    // Accumulator and kept condition.
    wire logic [upl_pkg::DW-1:0] next_acc =
        wrAcc                              ? regWrData[upl_pkg::DW-1:0] :
        ((state == ST_EXEC) && isAnd)      ? andRes :
        ((state == ST_EXEC) && isLoad)     ? memRdData :
        acc;
    wire logic [upl_pkg::DW-1:0] next_condVal =
        ((state == ST_EXEC) && isTest) ? andRes :
        ((state == ST_EXEC) && isCmp)  ? cmpRes :
        condVal;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc     <= upl_pkg::ACC_RESET;
            condVal <= upl_pkg::COND_RESET;
        end else begin
            acc     <= next_acc;
            condVal <= next_condVal;
        end
    end

    // Status flags; an unknown opcode halts and sets the sticky flag.
    // A new fault in the same cycle as a restart keeps the flag set.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            running <= 1'b0;
            illegal <= 1'b0;
        end else begin
            running <= (next_state != ST_IDLE);
            if (badOp) begin
                illegal <= 1'b1;
            end else if (runReq) begin
                illegal <= 1'b0;
            end
        end
    end

    // Read port: data stand for one cycle after the strobe, zero otherwise.
    wire logic [upl_pkg::RW-1:0] statusWord =
        upl_pkg::RW'({illegal, condZero, running});
    wire logic [upl_pkg::RW-1:0] rdMux =
        (regAddr == upl_pkg::REG_CONTROL) ? upl_pkg::RW'({running, pc}) :
        (regAddr == upl_pkg::REG_STATUS)  ? statusWord :
        (regAddr == upl_pkg::REG_ACC)     ? upl_pkg::RW'(acc) :
                                            upl_pkg::RW'(condVal);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= '0;
        end else begin
            regRdData <= regRd ? rdMux : '0;
        end
    end

    // Checks.
    a_fetch_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_CMD) |-> (memAddr == pc))
        else $error("command fetch address differs from program counter");

    a_and_acc: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && isAnd && !wrAcc) |=> (acc == ($past(subjVal) & $past(calcOperand))))
        else $error("AND result not in accumulator");

    a_and_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (andRes & ~subjVal) == '0 && (andRes & ~calcOperand) == '0 &&
        ((subjVal & calcOperand) == andRes))
        else $error("product bit wrong");

    a_test_acc_kept: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && (isTest || isCmp) && !wrAcc) |=> $stable(acc))
        else $error("accumulator changed by test or compare");

    a_cmp_zero_eq: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && isCmp) |=>
        ((condVal == '0) == ($past(subjVal) == $past(calcOperand))))
        else $error("compare result does not match equality");

    a_indirect_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_IND && needInd && !stopReq) |=> ##1
        (state == ST_EXEC && memAddr == opnd))
        else $error("indirect operand not fetched");

    a_branch_target: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && isBr && condSel == upl_pkg::COND_ALWAYS) |=> (pc == $past(opnd)))
        else $error("unconditional branch missed target");

    a_branch_cond: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && isBr && condSel == upl_pkg::COND_ZERO && !condZero) |=>
        (pc == $past(pc) + upl_pkg::LEN_LONG))
        else $error("failed zero branch did not fall through");

    a_pc_advance: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_EXEC && !isBr) |=> (pc == $past(pc) + upl_pkg::LEN_LONG))
        else $error("program counter did not advance by two");

    a_move_store: assert property (@(posedge clk) disable iff (sys_rst)
        (takeStore && !stopReq) |=> (memWr && memWrData == $past(subjVal) &&
                                     memAddr == $past(memRdData)))
        else $error("MOVE store not issued");

    a_queue_pop: assert property (@(posedge clk) disable iff (sys_rst)
        popInt |-> (((state == ST_EXEC && isCalc) || (state == ST_IND && isStore)) &&
                    subjSel == upl_pkg::SUBJ_INT))
        else $error("interrupt queue advanced without access");

    c_and_exec:   cover property (@(posedge clk) disable iff (sys_rst) state == ST_EXEC && isAnd);
    c_branch_tk:  cover property (@(posedge clk) disable iff (sys_rst) state == ST_EXEC && brTaken);
    c_move_store: cover property (@(posedge clk) disable iff (sys_rst) memWr);
    c_step_pop:   cover property (@(posedge clk) disable iff (sys_rst) popStep);
endmodule : upl_core

/* File: tb/upl_far_model.sv */
// Program memory and queued status sources standing opposite the engine.
`timescale 1ns/1ps
module upl_far_model (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Program memory
    input  wire logic [upl_pkg::AW-1:0] memAddr,
    output logic      [upl_pkg::DW-1:0] memRdData,
    input  wire logic                   memWr,
    input  wire logic [upl_pkg::DW-1:0] memWrData,
    // Queued sources
    input  wire logic                   popInt,
    input  wire logic                   popStep,
    output logic      [upl_pkg::DW-1:0] intStatus,
    output logic      [upl_pkg::DW-1:0] cmdStep
);
    logic [upl_pkg::DW-1:0] ram   [256];
    logic [upl_pkg::DW-1:0] intQ  [256];
    logic [upl_pkg::DW-1:0] stepQ [256];
    logic [7:0]             intIdx;
    logic [7:0]             stepIdx;

    // Each consumed entry uncovers the next held cause.
    assign intStatus = intQ[intIdx];
    assign cmdStep   = stepQ[stepIdx];

    always @(posedge clk) begin
        memRdData <= ram[memAddr];
        if (memWr) begin
            ram[memAddr] <= memWrData;
        end
        if (sys_rst) begin
            intIdx  <= 8'h00;
            stepIdx <= 8'h00;
        end else begin
            intIdx  <= intIdx + {7'h00, popInt};
            stepIdx <= stepIdx + {7'h00, popStep};
        end
    end
endmodule : upl_far_model

/* File: tb/upl_core_tb.sv */
// Self-checking bench for the user program engine.
`timescale 1ns/1ps
module upl_core_tb;
    logic        clk;
    logic        sys_rst;
    logic [1:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdData;
    logic [7:0]  memAddr;
    logic [7:0]  memRdData;
    logic        memWr;
    logic [7:0]  memWrData;
    logic [7:0]  rxByte0, rxByte1, ctrlStatus, nexusStatus, scsiCtrl, intStatus, cmdStep;
    logic        popInt;
    logic        popStep;
    int          nFail;
    int          nTests;
    logic [15:0] seed;
    logic [15:0] rd;
    logic [7:0]  acc0, acc1, accE, a, b, c, d, vs, vt, vr, cnd, ii, si;
    logic [2:0]  s, t, r;
    int          it;

    upl_core uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memAddr(memAddr),
        .memRdData(memRdData), .memWr(memWr), .memWrData(memWrData), .rxByte0(rxByte0),
        .rxByte1(rxByte1), .ctrlStatus(ctrlStatus), .nexusStatus(nexusStatus),
        .intStatus(intStatus), .cmdStep(cmdStep), .scsiCtrl(scsiCtrl), .popInt(popInt),
        .popStep(popStep));

    upl_far_model far (.clk(clk), .sys_rst(sys_rst), .memAddr(memAddr),
        .memRdData(memRdData), .memWr(memWr), .memWrData(memWrData), .popInt(popInt),
        .popStep(popStep), .intStatus(intStatus), .cmdStep(cmdStep));

    always #10 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // Value a subject code yields; queued sources advance their read index.
    function automatic logic [7:0] srcv(input logic [2:0] k, input logic [7:0] av,
                                        inout logic [7:0] qi, inout logic [7:0] qs);
        case (k)
            3'h0: return rxByte0;
            3'h1: return rxByte1;
            3'h2: return ctrlStatus;
            3'h3: return nexusStatus;
            3'h4: begin
                qi = qi + 8'h01;
                return far.intQ[qi - 8'h01];
            end
            3'h5: begin
                qs = qs + 8'h01;
                return far.stepQ[qs - 8'h01];
            end
            3'h6: return scsiCtrl;
            default: return av;
        endcase
    endfunction : srcv

    task automatic end_sim();
        if (nFail == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            nFail++;
        end
    endtask : chk

    task automatic wrReg(input logic [1:0] ad, input logic [15:0] dv);
        @(posedge clk);
        regAddr   <= ad;
        regWrData <= dv;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wrReg

    task automatic rdReg(input logic [1:0] ad, output logic [15:0] dv);
        @(posedge clk);
        regAddr <= ad;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        dv = regRdData;
    endtask : rdReg

    task automatic put(input logic [7:0] ad, input logic [7:0] b0, input logic [7:0] b1);
        far.ram[ad]         = b0;
        far.ram[ad + 8'h01] = b1;
    endtask : put

    // Starts at the given address and polls until the engine goes idle.
    task automatic runProg(input logic [15:0] cmd);
        int k;
        wrReg(upl_pkg::REG_CONTROL, cmd);
        rd = 16'h0001;
        for (k = 0; k < 300 && rd[0] === 1'b1; k++) begin
            rdReg(upl_pkg::REG_STATUS, rd);
        end
        if (rd[0] !== 1'b0) begin
            chk(rd & 16'h0001, 16'h0000);
            end_sim();
        end
    endtask : runProg

    initial begin
        clk = 1'b0;
        nFail = 0;
        nTests = 0;
        seed = 16'h95e0;
        sys_rst <= 1'b1;
        regAddr <= 2'h0;
        regWrData <= 16'h0000;
        regWr <= 1'b0;
        regRd <= 1'b0;
        {rxByte0, rxByte1, ctrlStatus, nexusStatus, scsiCtrl} <= 40'h00;
        for (it = 0; it < 256; it++) begin
            seed = lfsr(seed);
            far.ram[it] = 8'h00;
            far.intQ[it] = seed[7:0];
            far.stepQ[it] = seed[15:8];
        end
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rdReg(upl_pkg::REG_STATUS, rd);
        chk(rd, 16'h0002);
        rdReg(upl_pkg::REG_ACC, rd);
        chk(rd, {8'h00, upl_pkg::ACC_RESET});
        rdReg(upl_pkg::REG_COND, rd);
        chk(rd, {8'h00, upl_pkg::COND_RESET});
        for (it = 0; it < 30; it++) begin
            seed = lfsr(seed);
            {acc0, a} = seed;
            seed = lfsr(seed);
            b = (it == 0) ? 8'h00 : seed[7:0];
            d = seed[15:8];
            seed = lfsr(seed);
            {s, t, r} = seed[8:0];
            if (it == 1 || it == 2) begin
                s = 3'h3 + it[2:0];
                t = s;
                r = s;
            end
            @(posedge clk);
            rxByte0 <= seed[7:0];
            rxByte1 <= seed[15:8];
            seed = lfsr(seed);
            ctrlStatus <= seed[7:0];
            nexusStatus <= seed[15:8];
            scsiCtrl <= seed[11:4];
            wrReg(upl_pkg::REG_ACC, {8'h00, acc0});
            ii = far.intIdx;
            si = far.stepIdx;
            vs = srcv(s, acc0, ii, si);
            acc1 = vs & a;
            vt = srcv(t, acc1, ii, si);
            cnd = vt & b;
            accE = acc1;
            c = d ^ 8'h5a;
            if (cnd != 8'h00) begin
                vr = srcv(r, acc1, ii, si);
                if (seed[0]) c = vr;
                cnd = vr ^ c;
                if (cnd == 8'h00) accE = d;
            end
            put(8'h00, {4'h1, 1'b0, s}, a);
            put(8'h02, 8'h5f, 8'hf0);
            put(8'h04, {4'h2, 1'b1, t}, 8'hf1);
            put(8'h06, 8'h41, 8'h0a);
            put(8'h08, 8'h00, 8'h00);
            put(8'h0a, {4'h3, 1'b0, r}, c);
            put(8'h0c, 8'h42, 8'h10);
            put(8'h0e, 8'h00, 8'h00);
            put(8'h10, 8'h40, 8'h14);
            put(8'h12, 8'h00, 8'h00);
            put(8'h14, 8'h43, 8'h12);
            put(8'h16, {4'h5, 1'b0, s}, 8'hf3);
            put(8'h18, 8'h00, 8'h00);
            put(8'hf0, ~acc1, b);
            put(8'hf2, d, d);
            runProg(16'h0100);
            chk(rd & 16'h0007, (cnd == 8'h00) ? 16'h0006 : 16'h0004);
            rdReg(upl_pkg::REG_ACC, rd);
            chk(rd, {8'h00, accE});
            rdReg(upl_pkg::REG_COND, rd);
            chk(rd, {8'h00, cnd});
            chk({8'h00, far.ram[8'hf0]}, {8'h00, acc1});
            chk({far.intIdx, far.stepIdx}, {ii, si});
        end
        // A branch to itself keeps running until software stops it.
        put(8'h40, 8'h40, 8'h40);
        wrReg(upl_pkg::REG_CONTROL, 16'h0140);
        rdReg(upl_pkg::REG_STATUS, rd);
        chk(rd & 16'h0005, 16'h0001);
        wrReg(upl_pkg::REG_CONTROL, 16'h0000);
        rdReg(upl_pkg::REG_CONTROL, rd);
        chk(rd & 16'h01ff, 16'h0040);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdReg(upl_pkg::REG_ACC, rd);
        chk(rd, 16'h0000);
        end_sim();
    end
endmodule : upl_core_tb
